//--- design/adc_conversion_mode_control.v
`timescale 1ns/1ps
`include "adc_mode_regs.vh"

module adc_conversion_mode_control #(
	// Clock cycles per oscillator tick; lowered only to shorten simulation runs
	parameter OSC_DIV = `ADC_OSC_DIV
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        nrst_i,
	// Configuration write from the serial logic (same clock)
	input  wire        cfg_wr_i,
	input  wire        mode_i,
	input  wire        single_shot_start_i,
	input  wire [2:0]  gain_range_select_i,
	input  wire        temp_sensor_select_i,
	input  wire [2:0]  data_rate_i,
	// Modulator bitstream from the analog core (asynchronous)
	input  wire        mod_bit_i,
	// Configuration readback
	output reg         mode_o,
	output reg         single_shot_start_o,
	output reg  [2:0]  gain_range_select_o,
	output reg         temp_sensor_select_o,
	output reg  [2:0]  data_rate_o,
	// Analog core control
	output reg         powered_up_o,
	output reg         mod_clk_en_o,
	output reg  [2:0]  pga_gain_o,
	output reg         sense_temp_o,
	output reg  [22:0] full_scale_span_o,
	output reg  [11:0] lsb_weight_o,
	// Result to the serial logic
	output reg  [15:0] result_o,
	output reg         new_data_o,
	output reg         busy_o
);

	////////////////////////////////////////////////////////////////////////
	// Timing enables and input synchronisation

	wire osc_tick;
	wire mod_tick;

	osc_tick_divider #(
		.OSC_DIV    (OSC_DIV)
	) u_div (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.osc_tick_o (osc_tick),
		.mod_tick_o (mod_tick)
	);

	reg mod_meta_reg;
	reg mod_sync_reg;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mod_meta_reg <= 1'b0;
			mod_sync_reg <= 1'b0;
		end else begin
			mod_meta_reg <= mod_bit_i;
			mod_sync_reg <= mod_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration register

	localparam ST_PWRDN   = 1'b0;
	localparam ST_CONVERT = 1'b1;

	reg        state_reg;
	reg        state_next;
	wire       start_req;
	wire       cont_req;

	// A start is taken only from power-down; a start written while busy is dropped
	assign start_req = cfg_wr_i && single_shot_start_i && mode_i
		&& (state_reg == ST_PWRDN); // RL10 RL13
	// Continuous mode restarts from power-down by itself, no start bit needed
	assign cont_req  = (mode_o == 1'b0) && (state_reg == ST_PWRDN);

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_o               <= `ADC_MODE_RST; // RL7
			single_shot_start_o  <= `ADC_START_RST;
			gain_range_select_o  <= `ADC_GAIN_RST;
			temp_sensor_select_o <= `ADC_TEMP_SEL_RST;
			data_rate_o          <= `ADC_RATE_RST;
		end else begin
			if (cfg_wr_i) begin // RL17
				mode_o               <= mode_i; // RL9
				gain_range_select_o  <= gain_range_select_i;
				temp_sensor_select_o <= temp_sensor_select_i;
				data_rate_o          <= data_rate_i;
			end
			// Start bit never stays set: the conversion launches on the write
			single_shot_start_o <= 1'b0; // RL11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settings for the conversion about to start

	// A start arrives in the same write as its settings, so take them from
	// the write itself rather than from the readback that is still loading
	wire [2:0] start_rate;
	wire [2:0] start_gain;
	wire       start_temp;

	assign start_rate = start_req ? data_rate_i : data_rate_o;
	assign start_gain = start_req ? gain_range_select_i : gain_range_select_o;
	assign start_temp = start_req ? temp_sensor_select_i : temp_sensor_select_o;

	////////////////////////////////////////////////////////////////////////
	// Range and code weight

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			full_scale_span_o <= `ADC_SPAN_2V048;
			lsb_weight_o      <= `ADC_LSB_2V048;
		end else begin
			// Codes above the 0.512 V setting all fold onto 0.256 V
			case (gain_range_select_o) // RL1 RL2
			`ADC_GAIN_6V144: begin
				full_scale_span_o <= `ADC_SPAN_6V144;
				lsb_weight_o      <= `ADC_LSB_6V144;
			end
			`ADC_GAIN_4V096: begin
				full_scale_span_o <= `ADC_SPAN_4V096;
				lsb_weight_o      <= `ADC_LSB_4V096;
			end
			`ADC_GAIN_2V048: begin
				full_scale_span_o <= `ADC_SPAN_2V048;
				lsb_weight_o      <= `ADC_LSB_2V048;
			end
			`ADC_GAIN_1V024: begin
				full_scale_span_o <= `ADC_SPAN_1V024;
				lsb_weight_o      <= `ADC_LSB_1V024;
			end
			`ADC_GAIN_0V512: begin
				full_scale_span_o <= `ADC_SPAN_0V512;
				lsb_weight_o      <= `ADC_LSB_0V512;
			end
			default: begin
				full_scale_span_o <= `ADC_SPAN_0V256;
				lsb_weight_o      <= `ADC_LSB_0V256;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decimation table for the latched data rate

	reg  [2:0]  rate_reg;
	reg  [14:0] decim_len;
	reg  [22:0] scale_k;

	always @* begin
		case (rate_reg) // RL19
		3'h0: begin
			decim_len = `ADC_DECIM_R0;
			scale_k   = `ADC_SCALE_R0;
		end
		3'h1: begin
			decim_len = `ADC_DECIM_R1;
			scale_k   = `ADC_SCALE_R1;
		end
		3'h2: begin
			decim_len = `ADC_DECIM_R2;
			scale_k   = `ADC_SCALE_R2;
		end
		3'h3: begin
			decim_len = `ADC_DECIM_R3;
			scale_k   = `ADC_SCALE_R3;
		end
		3'h4: begin
			decim_len = `ADC_DECIM_R4;
			scale_k   = `ADC_SCALE_R4;
		end
		3'h5: begin
			decim_len = `ADC_DECIM_R5;
			scale_k   = `ADC_SCALE_R5;
		end
		3'h6: begin
			decim_len = `ADC_DECIM_R6;
			scale_k   = `ADC_SCALE_R6;
		end
		default: begin
			decim_len = `ADC_DECIM_R7;
			scale_k   = `ADC_SCALE_R7;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Filter: count ones, then map to a signed full-scale code

	reg  [14:0] samp_cnt_reg;
	reg  [14:0] ones_reg;
	reg         temp_reg;
	wire [14:0] ones_now;
	wire        last_samp;
	wire signed [16:0] diff;
	wire signed [40:0] prod;
	wire signed [24:0] scaled;
	reg  [15:0] code;

	// Ones density to signed code: 2*ones - N spans -N..+N and 2^31/N scales
	// that to +/-2^15; the top end lands one past 7FFF and is clipped below
	assign ones_now  = ones_reg + {14'h0000, mod_sync_reg};
	assign last_samp = mod_tick && (samp_cnt_reg == decim_len - 15'h0001);
	assign diff      = $signed({1'b0, ones_now, 1'b0}) - $signed({2'b00, decim_len});
	assign prod      = diff * $signed({1'b0, scale_k});
	assign scaled    = prod[40:16];

	always @* begin
		if (scaled > $signed({9'h000, `ADC_CODE_POS_FS}))
			code = `ADC_CODE_POS_FS;
		else if (scaled < $signed({9'h1FF, `ADC_CODE_NEG_FS}))
			code = `ADC_CODE_NEG_FS;
		else
			code = scaled[15:0];
		// Temperature: 14-bit two's complement at 0.03125 C, left-justified
		if (temp_reg)
			code = {code[15:`ADC_TEMP_PAD], 2'b00}; // RL5 RL6
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_PWRDN: begin
			if (start_req || cont_req)
				state_next = ST_CONVERT; // RL11
		end
		default: begin
			// Mode set to one aborts continuous running straight to power-down
			if (cfg_wr_i && mode_i && !mode_o)
				state_next = ST_PWRDN; // RL15
			else if (last_samp && mode_o)
				state_next = ST_PWRDN; // RL12
		end
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg    <= ST_PWRDN; // RL8
			rate_reg     <= `ADC_RATE_RST;
			temp_reg     <= `ADC_TEMP_SEL_RST;
			samp_cnt_reg <= 15'h0000;
			ones_reg     <= 15'h0000;
			result_o     <= 16'h0000;
			new_data_o   <= 1'b0;
			powered_up_o <= 1'b0;
			mod_clk_en_o <= 1'b0;
			busy_o       <= 1'b0;
			pga_gain_o   <= `ADC_GAIN_RST;
			sense_temp_o <= `ADC_TEMP_SEL_RST;
		end else begin
			state_reg    <= state_next;
			new_data_o   <= 1'b0;
			powered_up_o <= (state_next == ST_CONVERT);
			busy_o       <= (state_next == ST_CONVERT);
			mod_clk_en_o <= (state_next == ST_CONVERT) && osc_tick;
			if (state_reg == ST_PWRDN && state_next == ST_CONVERT) begin
				// Settings are frozen for the whole conversion
				rate_reg     <= start_rate;
				temp_reg     <= start_temp;
				pga_gain_o   <= start_gain;
				sense_temp_o <= start_temp; // RL4
				samp_cnt_reg <= 15'h0000;
				ones_reg     <= 15'h0000;
			end else if (state_reg == ST_CONVERT && mod_tick) begin
				if (last_samp) begin
					result_o     <= code; // RL14 RL19
					new_data_o   <= 1'b1; // RL20
					samp_cnt_reg <= 15'h0000;
					ones_reg     <= 15'h0000;
					// Next continuous conversion picks up fresh settings
					rate_reg     <= data_rate_o;
					temp_reg     <= temp_sensor_select_o;
					pga_gain_o   <= gain_range_select_o;
					sense_temp_o <= temp_sensor_select_o;
				end else begin
					samp_cnt_reg <= samp_cnt_reg + 15'h0001;
					ones_reg     <= ones_now;
				end
			end
		end
	end

endmodule // adc_conversion_mode_control

//--- design/adc_mode_regs.vh
// Overview of operation
// (RL1) Three-bit gain field picks one of six full-scale ranges, 6.144 V to 0.256 V.
// (RL2) One code step weighs the full-scale span over two to the sixteenth.
// (RL3) All timing comes from an internal 1 MHz tick; data rate scales with it.
// (RL4) Temperature select bit set converts the internal sensor instead of inputs.
// (RL5) Temperature result is 14 bits, left-justified in the 16-bit word, MSB first.
// (RL6) Temperature step is 0.03125 C, negatives in two's complement.
// (RL7) Power-up reset loads every configuration bit with its default.
// (RL8) After start-up the converter sits powered down, logic active, no conversions.
// (RL9) Mode bit one selects single-shot with power-down; zero selects continuous.
// (RL10) Powered down in single-shot, config writes still work until start bit written.
// (RL11) Writing start powers up, clears start bit, runs exactly one conversion.
// (RL12) Single-shot returns to power-down once the result is ready.
// (RL13) Start written during a running conversion is ignored, not queued.
// (RL14) Continuous mode stores each result and starts the next conversion at once.
// (RL15) Leaving continuous needs mode written to one or reset; then single-shot power-down.
// (RL16) Host may duty-cycle single-shot conversions at any interval it likes.
// (RL17) Serial link carries reads, writes and control over chip select and three lines.
// (RL18) Modulator sampling clock is the 1 MHz oscillator divided by four.
// (RL19) Continuous conversions finish at the programmed rate; reads see the latest.
// (RL20) Every completed conversion raises a new-data pulse for the serial logic.
`ifndef ADC_MODE_REGS_VH
`define ADC_MODE_REGS_VH

// Clocking
`define ADC_CLK_FREQ_HZ      250000000
`define ADC_OSC_FREQ_HZ      1000000
`define ADC_OSC_DIV          (`ADC_CLK_FREQ_HZ / `ADC_OSC_FREQ_HZ)
`define ADC_MOD_DIV          4

// Configuration defaults
`define ADC_MODE_RST         1'b1
`define ADC_START_RST        1'b0
`define ADC_GAIN_RST         3'h2
`define ADC_TEMP_SEL_RST     1'b0
`define ADC_RATE_RST         3'h4

// Gain field codes
`define ADC_GAIN_6V144       3'h0
`define ADC_GAIN_4V096       3'h1
`define ADC_GAIN_2V048       3'h2
`define ADC_GAIN_1V024       3'h3
`define ADC_GAIN_0V512       3'h4

// Full-scale span, microvolts (peak of the +/- range)
`define ADC_SPAN_6V144       23'h5D_C000
`define ADC_SPAN_4V096       23'h3E_8000
`define ADC_SPAN_2V048       23'h1F_4000
`define ADC_SPAN_1V024       23'h0F_A000
`define ADC_SPAN_0V512       23'h07_D000
`define ADC_SPAN_0V256       23'h03_E800

// Code weight in sixteenths of a microvolt
`define ADC_LSB_6V144        12'hB_B8
`define ADC_LSB_4V096        12'h7_D0
`define ADC_LSB_2V048        12'h3_E8
`define ADC_LSB_1V024        12'h1_F4
`define ADC_LSB_0V512        12'h0_FA
`define ADC_LSB_0V256        12'h0_7D

// Modulator samples per conversion, per data-rate code
`define ADC_DECIM_R0         15'h7A12
`define ADC_DECIM_R1         15'h3D09
`define ADC_DECIM_R2         15'h1E84
`define ADC_DECIM_R3         15'h0F42
`define ADC_DECIM_R4         15'h07A1
`define ADC_DECIM_R5         15'h03E8
`define ADC_DECIM_R6         15'h020E
`define ADC_DECIM_R7         15'h0122

// Scale factor 2^31 / samples, per data-rate code
`define ADC_SCALE_R0         23'h01_0C6F
`define ADC_SCALE_R1         23'h02_18DE
`define ADC_SCALE_R2         23'h04_31D2
`define ADC_SCALE_R3         23'h08_63A4
`define ADC_SCALE_R4         23'h10_C748
`define ADC_SCALE_R5         23'h20_C49B
`define ADC_SCALE_R6         23'h3E_4BEC
`define ADC_SCALE_R7         23'h70_FE08

// Result clipping and temperature justification
`define ADC_CODE_POS_FS      16'h7FFF
`define ADC_CODE_NEG_FS      16'h8000
`define ADC_TEMP_PAD         2

`endif

//--- design/osc_tick_divider.v
`timescale 1ns/1ps
`include "adc_mode_regs.vh"

module osc_tick_divider #(
	// Clock cycles per oscillator tick
	parameter OSC_DIV = `ADC_OSC_DIV
) (
	// Clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// Derived enables
	output reg        osc_tick_o,
	output reg        mod_tick_o
);

	localparam integer OSC_LAST_I = OSC_DIV - 1;
	localparam integer MOD_LAST_I = `ADC_MOD_DIV - 1;
	localparam [7:0]   OSC_LAST   = OSC_LAST_I[7:0];
	localparam [1:0]   MOD_LAST   = MOD_LAST_I[1:0];

	reg [7:0] osc_cnt_reg;
	reg [1:0] mod_cnt_reg;

	// 1 MHz tick from the 250 MHz clock, modulator tick every fourth one
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osc_cnt_reg <= 8'h00;
			mod_cnt_reg <= 2'h0;
			osc_tick_o  <= 1'b0;
			mod_tick_o  <= 1'b0;
		end else begin
			osc_tick_o <= 1'b0;
			mod_tick_o <= 1'b0;
			if (osc_cnt_reg == OSC_LAST) begin
				osc_cnt_reg <= 8'h00;
				osc_tick_o  <= 1'b1; // RL3
				if (mod_cnt_reg == MOD_LAST) begin
					mod_cnt_reg <= 2'h0;
					mod_tick_o  <= 1'b1; // RL18
				end else begin
					mod_cnt_reg <= mod_cnt_reg + 2'h1;
				end
			end else begin
				osc_cnt_reg <= osc_cnt_reg + 8'h01;
			end
		end
	end

endmodule // osc_tick_divider

//--- sim/adc_mode_checker.sv
`timescale 1ns/1ps
module adc_mode_checker (
	input logic        clk_i,
	input logic        nrst_i,
	input logic        cfg_wr_i,
	input logic        mode_i,
	input logic        single_shot_start_i,
	input logic        mode_o,
	input logic        single_shot_start_o,
	input logic [2:0]  gain_range_select_o,
	input logic [2:0]  data_rate_o,
	input logic        powered_up_o,
	input logic        mod_clk_en_o,
	input logic        sense_temp_o,
	input logic [22:0] full_scale_span_o,
	input logic [11:0] lsb_weight_o,
	input logic [15:0] result_o,
	input logic        new_data_o,
	input logic        busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	reset_defaults_a: assert property ($rose(nrst_i) |-> mode_o && !busy_o
		&& gain_range_select_o == 3'h2 && data_rate_o == 3'h4) else $error("bad defaults");
	start_clear_a: assert property (cfg_wr_i && single_shot_start_i |=>
		!single_shot_start_o) else $error("start bit stuck");
	start_power_a: assert property (cfg_wr_i && mode_i && single_shot_start_i && !busy_o
		|=> busy_o && powered_up_o) else $error("start not taken");
	ignore_start_a: assert property (cfg_wr_i && mode_i && single_shot_start_i && busy_o
		&& mode_o && !new_data_o |=> busy_o != new_data_o) else $error("busy start disturbed");
	single_done_a: assert property (new_data_o && mode_o |=> !busy_o)
		else $error("no power-down after result");
	cont_restart_a: assert property (new_data_o && !mode_o && !(cfg_wr_i && mode_i) |=> busy_o)
		else $error("continuous stopped");
	cont_abort_a: assert property (cfg_wr_i && mode_i && !mode_o && busy_o |=> !busy_o)
		else $error("abort ignored");
	idle_quiet_a: assert property (!busy_o && $past(!busy_o) |-> !mod_clk_en_o)
		else $error("modulator runs idle");
	mode_readback_a: assert property (cfg_wr_i |=> mode_o == $past(mode_i))
		else $error("mode not loaded");
	code_weight_a: assert property ({lsb_weight_o, 11'h000} == full_scale_span_o)
		else $error("weight not span over 2^16");
	temp_pad_a: assert property (new_data_o && $past(sense_temp_o) |-> result_o[1:0] == 2'h0)
		else $error("temperature not left-justified");
	cover property (new_data_o && mode_o);
	cover property (new_data_o && !mode_o);
	cover property (cfg_wr_i && mode_i && !mode_o && busy_o);
endmodule // adc_mode_checker
////////////////////////////////////////////////////////////////
bind adc_conversion_mode_control adc_mode_checker u_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .mode_i(mode_i),
	.single_shot_start_i(single_shot_start_i), .mode_o(mode_o),
	.single_shot_start_o(single_shot_start_o), .gain_range_select_o(gain_range_select_o),
	.data_rate_o(data_rate_o), .powered_up_o(powered_up_o), .mod_clk_en_o(mod_clk_en_o),
	.sense_temp_o(sense_temp_o), .full_scale_span_o(full_scale_span_o),
	.lsb_weight_o(lsb_weight_o), .result_o(result_o), .new_data_o(new_data_o),
	.busy_o(busy_o));

//--- sim/mod_source.sv
`timescale 1ns/1ps
// Stands in for the analog modulator: a steady level gives a full-scale code
module mod_source (
	input  wire logic level_i,
	output logic      mod_bit_o
);
	// Async to clk_i on purpose; the design synchronises it
	assign #1.3 mod_bit_o = level_i;
endmodule // mod_source

//--- sim/adc_conversion_mode_control_bench.sv
`timescale 1ns/1ps
module adc_conversion_mode_control_bench;
	logic clk_i = 0, nrst_i = 0, cfg_wr_i = 0, mode_i = 1, start_i = 0, temp_i = 0, lvl = 1;
	logic [2:0] gain_i = 0, rate_i = 0;
	logic mod_bit, mode_o, ss_o, temp_o, pwr_o, mclk_o, stemp_o, nd_o, busy_o;
	logic [2:0] gain_o, rate_o, pga_o;
	logic [22:0] span_o;
	logic [11:0] lsb_o;
	logic [15:0] result_o;
	int bad_count = 0, check_count = 0, cyc = 0, n, g, seed;
	int exp_q[$];
	// Shortened oscillator; a rate-7 conversion is 290 samples of 4 ticks each
	localparam int DIV = 4, CONV = 290 * 4 * DIV;
	initial forever #2 clk_i = ~clk_i;
	mod_source u_src (.level_i(lvl), .mod_bit_o(mod_bit));
	adc_conversion_mode_control #(.OSC_DIV(DIV)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.cfg_wr_i(cfg_wr_i),
		.mode_i(mode_i), .single_shot_start_i(start_i), .gain_range_select_i(gain_i),
		.temp_sensor_select_i(temp_i), .data_rate_i(rate_i), .mod_bit_i(mod_bit),
		.mode_o(mode_o), .single_shot_start_o(ss_o), .gain_range_select_o(gain_o),
		.temp_sensor_select_o(temp_o), .data_rate_o(rate_o), .powered_up_o(pwr_o),
		.mod_clk_en_o(mclk_o), .pga_gain_o(pga_o), .sense_temp_o(stemp_o),
		.full_scale_span_o(span_o), .lsb_weight_o(lsb_o), .result_o(result_o),
		.new_data_o(nd_o), .busy_o(busy_o));
	////////////////////////////////////////////////////////////////
	task summarize;
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [22:0] seen, input logic [22:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic m, input logic s, input logic [2:0] gn, input logic t);
		@(negedge clk_i);
		{cfg_wr_i, mode_i, start_i, gain_i, temp_i, rate_i} = {1'b1, m, s, gn, t, 3'h7};
		@(negedge clk_i);
		cfg_wr_i = 0;
	endtask
	// Waits for a result and compares it with the oldest queued expectation
	task wait_nd;
		n = 0;
		while (nd_o !== 1'b1 && n < 2 * CONV) begin
			@(negedge clk_i);
			n++;
		end
		chk(result_o, exp_q.pop_front());
		chk(n > CONV - 80 && n < CONV + 4, 1);
	endtask
	function int span_uv(int gc);
		return gc == 0 ? 6144000 : 4096000 >> ((gc > 5 ? 5 : gc) - 1);
	endfunction
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			summarize;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(32'h9794);
		repeat (6) @(negedge clk_i);
		nrst_i = 1;
		@(negedge clk_i);
		chk({mode_o, gain_o, rate_o, temp_o, busy_o}, {1'b1, 3'h2, 3'h4, 2'b00});
		chk(span_o, 2048000);
		chk(result_o, 0);
		for (int i = 0; i < 12; i++) begin
			g = $urandom % 8;
			wr(1, 0, g, g[0]);
			@(negedge clk_i);
			chk(span_o, span_uv(g));
			chk(lsb_o, span_uv(g) / 2048);
			chk({gain_o, temp_o, busy_o, ss_o}, {g[2:0], g[0], 2'b00});
		end
		exp_q.push_back(16'h7FFF);
		wr(1, 1, 0, 0);
		chk({busy_o, ss_o}, 2'b10);
		repeat (50) @(negedge clk_i);
		wr(1, 1, 1, 0);
		wait_nd;
		repeat (2) @(negedge clk_i);
		chk(busy_o, 0);
		repeat (2000) @(negedge clk_i);
		chk(busy_o, 0);
		exp_q.push_back(16'h7FFC);
		wr(1, 1, 4, 1);
		chk({pga_o, stemp_o, pwr_o}, {3'h4, 2'b11});
		wait_nd;
		exp_q.push_back(16'h7FFC);
		exp_q.push_back(16'h8000);
		wr(0, 0, 2, 1);
		wait_nd;
		lvl = 0;
		chk(result_o[1:0], 0);
		@(negedge clk_i);
		chk(busy_o, 1);
		wait_nd;
		repeat (10) @(negedge clk_i);
		wr(1, 0, 2, 1);
		chk(busy_o, 0);
		repeat (1500) @(negedge clk_i);
		chk({busy_o, result_o}, {1'b0, 16'h8000});
		wr(0, 0, 3, 0);
		repeat (20) @(negedge clk_i);
		chk(busy_o, 1);
		nrst_i = 0;
		repeat (2) @(negedge clk_i);
		nrst_i = 1;
		@(negedge clk_i);
		chk({mode_o, gain_o, busy_o, result_o}, {1'b1, 3'h2, 17'h0});
		summarize;
	end
endmodule // adc_conversion_mode_control_bench
